// file: core/adc_power_mode_sequencer.sv
// power-mode and transfer control of a serial successive-approximation converter
// assumes pins are asynchronous; result_i comes from logic on mclk_i
//
// Behaviour
// - power bits pick normal, off, auto-shutdown, standby
// - chip select fall starts conversion, holds sample
// - write bit set loads first 12 bits
// - armed shadow transfer loads all 16 bits
// - sixteen clocks; track resumes at 14th fall
// - full shutdown keeps word until power rewritten
// - write normal in shutdown powers up at rise
// - auto-shutdown sleeps after conversion, sample held
// - auto-shutdown wakes, tracks on next chip select fall
// - auto-standby sleeps after conversion, bias stays on
// - standby wakes and tracks on next fall
// - new auto mode takes effect at conversion end
// - three dummy transfers reach an auto mode
// - third rise after power-up holds configuration
// - write bit is input word msb
// - shadow word commits at rise, tracking restarts in normal mode
// - output word: four address bits, twelve result
`timescale 1ns/10ps
`default_nettype none
module adc_power_mode_sequencer
    import adc_power_pkg::*;
#(
    // power-up contents are unspecified; this value is arbitrary
    parameter logic [CTRL_BITS-1:0] POWERUP_CTRL = 12'h0A5
) (
    input wire logic mclk_i,
    input wire logic reset_i, // models supply application
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic [RES_BITS-1:0] result_i, // conversion result
    output logic dout_o,
    output logic dout_oe_o,
    output logic track_o, // 1 track, 0 hold
    output logic [1:0] pwr_state_o, // pwr_state_t code
    output logic conv_start_o, // pulse per conversion start
    output logic config_valid_o, // init sequence finished
    output logic [CTRL_BITS-1:0] ctrl_word_o,
    output logic [WORD_BITS-1:0] seq_word_o
);
    ////////////////////////////////////////////////////////////////////////
    // pin front end
    // every pin passes two flops and then an edge compare or, for din_i, a third flop, so a pin event
    // reaches the sequencer three clock edges after the pin moved, and the
    // state below answers on the fourth; this caps the serial clock at about
    // an eighth of mclk_i, traded for a single clock domain
    pin_event_if evt ();

    pin_sampler u_sampler (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .cs_n_i(cs_n_i),
        .sclk_i(sclk_i),
        .din_i(din_i),
        .evt(evt)
    );

    ////////////////////////////////////////////////////////////////////////
    // all sequencer state in one record
    // one record so that a single flop bank holds the whole sequencer
    typedef struct packed {
        logic [CNT_BITS-1:0] cnt; // falling clock edges this frame
        logic [WORD_BITS-1:0] shin; // bits taken from serial input
        logic [WORD_BITS-1:0] shout; // word being shifted out
        logic [CTRL_BITS-1:0] ctrl; // control word
        logic [WORD_BITS-1:0] seq; // channel-sequence word
        logic shadow_arm; // last write asked for a shadow frame
        logic shadow_xfer; // this frame feeds the sequence word
        logic in_frame; // between chip select fall and rise
        pwr_state_t pwr;
        logic track;
        logic dout;
        logic dout_oe;
        logic conv_start;
        logic [1:0] rises; // chip select rises since power-up
        logic cfg_valid;
    } seq_state_t;

    seq_state_t st_r;
    seq_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // next state
    // pin events are taken by priority: a chip select fall wins over a clock
    // fall, and a clock fall wins over a chip select rise
    // limitation: a chip select rise in the same cycle as a counted clock fall (one of the
    // first sixteen in a frame) is lost, so the host must keep the two apart
    // the shift register and counter run in every mode; only the track flag
    // and the power state depend on the mode
    always_comb begin
        logic [WORD_BITS-1:0] shin_new;
        logic [CNT_BITS-1:0] cnt_new;
        shin_new = {st_r.shin[WORD_BITS-2:0], evt.din_lvl};
        cnt_new = st_r.cnt + 5'h01;
        st_nxt = st_r;
        st_nxt.conv_start = 1'b0;

        if (evt.cs_fall) begin
            // new conversion: sample held, counter restarts
            st_nxt.in_frame = 1'b1;
            st_nxt.cnt = '0;
            st_nxt.conv_start = 1'b1;
            st_nxt.track = 1'b0;
            st_nxt.shadow_xfer = st_r.shadow_arm;
            st_nxt.shadow_arm = 1'b0;
            // address nibble then result, msb leads on the fall
            st_nxt.shout = {st_r.ctrl[ADDR_HI:ADDR_LO], result_i};
            st_nxt.dout = st_r.ctrl[ADDR_HI];
            st_nxt.dout_oe = 1'b1;
            // a sleeping core wakes here; this transfer is the dummy
            if (st_r.pwr == PWR_SHUTDOWN || st_r.pwr == PWR_STANDBY) begin
                st_nxt.pwr = PWR_ACTIVE;
                st_nxt.track = 1'b1;
            end
        end else if (evt.sclk_fall && st_r.in_frame && st_r.cnt < LAST_EDGE) begin
            // clocks beyond sixteen are ignored until the next start
            // shin collects every bit; the count decides what it feeds
            st_nxt.cnt = cnt_new;
            st_nxt.shin = shin_new;
            st_nxt.shout = {st_r.shout[WORD_BITS-2:0], 1'b0};
            st_nxt.dout = st_r.shout[WORD_BITS-2];
            // control load needs the write flag as first bit
            if (cnt_new == CTRL_LOAD_EDGE && !st_r.shadow_xfer
                    && shin_new[WRITE_POS]) begin
                st_nxt.ctrl = shin_new[CTRL_BITS-1:0];
                st_nxt.shadow_arm = ~shin_new[SEQ_POS] & shin_new[SHADOW_POS];
            end
            // a held core that is powered returns to track here
            if (cnt_new == TRACK_EDGE && !st_r.shadow_xfer
                    && st_r.pwr == PWR_ACTIVE) begin
                st_nxt.track = 1'b1;
            end
            // output released after the last bit
            // dout is driven low while released so no unknown leaves the block
            if (cnt_new == LAST_EDGE) begin
                st_nxt.dout_oe = 1'b0;
                st_nxt.dout = 1'b0;
            end
        end else if (evt.cs_rise) begin
            st_nxt.in_frame = 1'b0;
            st_nxt.dout_oe = 1'b0;
            st_nxt.dout = 1'b0;
            // shadow frame commits the word, then tracks first channel if the power pair is normal
            // a cut shadow frame, fewer than sixteen falls, leaves the word alone
            if (st_r.shadow_xfer && st_r.cnt == LAST_EDGE) begin
                st_nxt.seq = st_r.shin;
                st_nxt.track = 1'b1;
            end
            st_nxt.shadow_xfer = 1'b0;
            // end of conversion: mode change lands only now
            // the power pair is read from the word as it stands here, so a
            // write in this frame takes effect now, and a dummy frame with the
            // write bit clear keeps the previous mode
            case ({st_r.ctrl[PWR_HI_POS], st_r.ctrl[PWR_LO_POS]})
                PM_NORMAL: begin
                    // also the power-up path out of full shutdown
                    // track stays held here; a core leaving full-off first
                    // tracks at the fourteenth clock fall of the next frame
                    st_nxt.pwr = PWR_ACTIVE;
                end
                PM_FULL_OFF: begin
                    // everything off, word kept, stays till rewritten
                    st_nxt.pwr = PWR_FULL_OFF;
                    st_nxt.track = 1'b0;
                end
                PM_AUTO_SHUT: begin
                    st_nxt.pwr = PWR_SHUTDOWN;
                    st_nxt.track = 1'b0;
                end
                default: begin
                    // bias generator stays up; core parts off
                    st_nxt.pwr = PWR_STANDBY;
                    st_nxt.track = 1'b0;
                end
            endcase
            // count init rises; third one holds written setup
            // the count stops at three, so it never wraps back
            if (st_r.rises != INIT_RISES) begin
                st_nxt.rises = st_r.rises + 2'h1;
                if (st_r.rises == INIT_RISES - 2'h1) begin
                    st_nxt.cfg_valid = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register; reset stands for supply application
    // the part has no reset pin; reset_i only models power arriving and
    // loads a deliberately odd setup, so nothing may rely on it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r <= '0;
            st_r.ctrl <= POWERUP_CTRL;
            st_r.seq <= SEQ_RESET;
            st_r.pwr <= PWR_FULL_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state record
    // every output is a field of st_r, so no gate follows any output flop
    assign dout_o = st_r.dout;
    assign dout_oe_o = st_r.dout_oe;
    assign track_o = st_r.track;
    assign pwr_state_o = st_r.pwr;
    assign conv_start_o = st_r.conv_start;
    assign config_valid_o = st_r.cfg_valid;
    assign ctrl_word_o = st_r.ctrl;
    assign seq_word_o = st_r.seq;
endmodule : adc_power_mode_sequencer
`default_nettype wire

// file: core/adc_power_pkg.sv
// constants shared by the power-mode sequencer and its pin front end
// assumes a single 100 MHz system clock samples every serial pin
package adc_power_pkg;
    // serial word geometry
    localparam int WORD_BITS = 16;
    localparam int CTRL_BITS = 12;
    localparam int RES_BITS = 12;
    localparam int CNT_BITS = 5;
    // falling-edge counts inside a transfer
    localparam logic [CNT_BITS-1:0] CTRL_LOAD_EDGE = 5'h0C;
    localparam logic [CNT_BITS-1:0] TRACK_EDGE = 5'h0E;
    localparam logic [CNT_BITS-1:0] LAST_EDGE = 5'h10;
    // control word field positions
    localparam int WRITE_POS = 11;
    localparam int SEQ_POS = 10;
    localparam int ADDR_HI = 9;
    localparam int ADDR_LO = 6;
    localparam int PWR_HI_POS = 5;
    localparam int PWR_LO_POS = 4;
    localparam int SHADOW_POS = 3;
    // power management bit pairs {high, low}
    localparam logic [1:0] PM_NORMAL = 2'h3;
    localparam logic [1:0] PM_FULL_OFF = 2'h2;
    localparam logic [1:0] PM_AUTO_SHUT = 2'h1;
    localparam logic [1:0] PM_AUTO_STBY = 2'h0;
    // dummy transfers needed after supply application
    localparam logic [1:0] INIT_RISES = 2'h3;
    // reset values
    localparam logic [WORD_BITS-1:0] SEQ_RESET = 16'h0000;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 12'h000;

    // power state of the analog core
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_SHUTDOWN = 2'b10,
        PWR_FULL_OFF = 2'b11
    } pwr_state_t;
endpackage : adc_power_pkg

// file: core/pin_event_if.sv
// interface carrying synchronised pin levels and edge events
// assumes producer and consumer share mclk_i
`timescale 1ns/10ps
`default_nettype none
interface pin_event_if;
    logic cs_fall; // chip select went low, one-cycle pulse
    logic cs_rise; // chip select went high, one-cycle pulse
    logic sclk_fall; // serial clock fell, one-cycle pulse
    logic din_lvl; // synchronised serial input level
    modport src (output cs_fall, output cs_rise, output sclk_fall, output din_lvl);
    modport dst (input cs_fall, input cs_rise, input sclk_fall, input din_lvl);
endinterface : pin_event_if
`default_nettype wire

// file: core/pin_sampler.sv
// two-flop synchronisers and edge finders for the serial pins
// assumes pins are asynchronous to mclk_i and much slower than it
`timescale 1ns/10ps
`default_nettype none
module pin_sampler
    import adc_power_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    pin_event_if.src evt
);
    // one packed record of all sampler state
    typedef struct packed {
        logic [2:0] meta; // first stage, read only by stage two
        logic [2:0] sync; // second stage, safe to use
        logic [2:0] last; // previous safe sample for edges
        logic cs_fall;
        logic cs_rise;
        logic sclk_fall;
    } samp_t;

    samp_t st_r;
    samp_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // next state: edges come only from the second stage
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = {cs_n_i, sclk_i, din_i};
        st_nxt.sync = st_r.meta;
        st_nxt.last = st_r.sync;
        st_nxt.cs_fall = st_r.last[2] & ~st_r.sync[2];
        st_nxt.cs_rise = ~st_r.last[2] & st_r.sync[2];
        st_nxt.sclk_fall = st_r.last[1] & ~st_r.sync[1];
    end

    // register; idle chip select high so no false edge after reset
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r <= '{meta: 3'h6, sync: 3'h6, last: 3'h6, default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt.cs_fall = st_r.cs_fall;
    assign evt.cs_rise = st_r.cs_rise;
    assign evt.sclk_fall = st_r.sclk_fall;
    assign evt.din_lvl = st_r.last[0];
endmodule : pin_sampler
`default_nettype wire

// file: verif/adc_power_mode_sequencer_sva.sv
// assertions on the power-mode sequencer top ports
// assumes a bind onto the top module and a single mclk_i domain
`timescale 1ns/10ps
`default_nettype none
module adc_power_mode_sequencer_sva
    import adc_power_pkg::*;
#(
    parameter logic [CTRL_BITS-1:0] POWERUP_CTRL = 12'h0A5
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic dout_oe_o,
    input wire logic track_o,
    input wire logic [1:0] pwr_state_o,
    input wire logic conv_start_o,
    input wire logic config_valid_o,
    input wire logic [CTRL_BITS-1:0] ctrl_word_o,
    input wire logic [WORD_BITS-1:0] seq_word_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////
    // start of a transfer: chip select fall, then the synchroniser delay
    sequence s_start; $fell(cs_n_i); endsequence
    sequence s_conv; ##[2:6] conv_start_o; endsequence
    property p_reset;
        disable iff (1'b0) reset_i |=> pwr_state_o == 2'h3 && ctrl_word_o == POWERUP_CTRL;
    endproperty
    property p_conv; s_start |-> s_conv; endproperty
    property p_once; conv_start_o |=> !conv_start_o; endproperty
    property p_hold; conv_start_o && $past(pwr_state_o) == 2'h0 |-> !track_o; endproperty
    property p_wake;
        conv_start_o && $past(pwr_state_o) inside {2'h1, 2'h2} |-> track_o && pwr_state_o == 2'h0;
    endproperty
    property p_sleep; pwr_state_o != 2'h0 |-> !track_o; endproperty
    property p_cfg; config_valid_o |=> config_valid_o; endproperty
    // control word only moves while a transfer drives the output
    property p_ctrl; $changed(ctrl_word_o) |-> $past(dout_oe_o) && !cs_n_i; endproperty
    property p_seq; $changed(seq_word_o) |-> track_o && !dout_oe_o; endproperty
    property p_mode;
        $changed(pwr_state_o) && !conv_start_o |-> !dout_oe_o && pwr_state_o ==
            {ctrl_word_o[PWR_HI_POS] ^ ctrl_word_o[PWR_LO_POS], !ctrl_word_o[PWR_LO_POS]};
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset state");
    a_conv: assert property (p_conv) else $error("no start pulse");
    a_once: assert property (p_once) else $error("start pulse too long");
    a_hold: assert property (p_hold) else $error("no hold at start");
    a_wake: assert property (p_wake) else $error("no wake at start");
    a_sleep: assert property (p_sleep) else $error("track while asleep");
    a_cfg: assert property (p_cfg) else $error("config flag dropped");
    a_ctrl: assert property (p_ctrl) else $error("control moved idle");
    a_seq: assert property (p_seq) else $error("bad sequence commit");
    a_mode: assert property (p_mode) else $error("bad power mode");
endmodule : adc_power_mode_sequencer_sva
bind adc_power_mode_sequencer adc_power_mode_sequencer_sva #(.POWERUP_CTRL(POWERUP_CTRL)) u_sva (
    .mclk_i(mclk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .dout_oe_o(dout_oe_o),
    .track_o(track_o), .pwr_state_o(pwr_state_o), .conv_start_o(conv_start_o),
    .config_valid_o(config_valid_o), .ctrl_word_o(ctrl_word_o), .seq_word_o(seq_word_o));
`default_nettype wire

// file: verif/host_port_model.sv
// host serial port: drives chip select, serial clock and input word
// assumes mclk_i at 100 MHz; serial clock averages a 125 ns period
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
    input wire logic mclk_i,
    input wire logic dout_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o
);
    int hp = 0; // half period index
    logic [15:0] rx; // word read back
    initial begin
        cs_n_o = 1'b1; // idle high between transfers
        sclk_o = 1'b1; // clock stands still outside frames
        din_o = 1'b0;
    end
    // halves of 6,6,6,7 cycles give 125 ns per period on average
    task automatic half();
        repeat ((hp % 4 == 3) ? 7 : 6) @(posedge mclk_i);
        hp++;
    endtask : half
    task automatic frame(input logic [15:0] w);
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        din_o <= w[15];
        for (int i = 15; i >= 0; i--) begin // sixteen clocks a frame
            half();
            rx[i] = dout_i;
            sclk_o <= 1'b0;
            half();
            sclk_o <= 1'b1;
            din_o <= (i > 0) ? w[i-1] : !w[0]; // released input never repeats
        end
        cs_n_o <= 1'b1;
        repeat (20) @(posedge mclk_i); // quiet and power-up time
    endtask : frame
endmodule : host_port_model
`default_nettype wire

// file: verif/test_adc_power_mode_sequencer.sv
// self-checking bench for the power-mode sequencer
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t: got %h exp %h", $time, a, b); end end
module test_adc_power_mode_sequencer;
    import adc_power_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [RES_BITS-1:0] result_i = 12'h000;
    logic cs_n, sclk, din, dout, track_o, config_valid_o;
    logic [1:0] pwr_state_o;
    logic [CTRL_BITS-1:0] ctrl_word_o, exp_ctrl = 12'h0A5;
    logic [WORD_BITS-1:0] seq_word_o, exp_seq = 16'h0000;
    logic [15:0] q[$]; // expected output words
    logic armed = 1'b0;
    logic [1:0] prev_pwr = 2'h3; // power state before the current frame
    logic [15:0] exp_word; // oldest note taken off the queue
    logic [31:0] rv;
    int seed, failures = 0, checks_done = 0;
    adc_power_mode_sequencer DUT (
        .mclk_i(mclk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
        .result_i(result_i), .dout_o(dout), .dout_oe_o(), .track_o(track_o),
        .pwr_state_o(pwr_state_o), .conv_start_o(), .config_valid_o(config_valid_o),
        .ctrl_word_o(ctrl_word_o), .seq_word_o(seq_word_o));
    host_port_model u_host (.mclk_i(mclk_i), .dout_i(dout), .cs_n_o(cs_n), .sclk_o(sclk),
        .din_o(din));
    initial forever #5 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////
    // compare each read word as its frame closes
    always @(posedge cs_n) if (!reset_i) begin
        exp_word = q.pop_front();
        `CHK(u_host.rx, exp_word);
    end
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // one transfer with its expected word and end state
    task automatic xfer(input logic [15:0] w);
        logic [1:0] pm;
        rv = $random(seed);
        result_i <= rv[11:0];
        q.push_back({exp_ctrl[9:6], rv[11:0]});
        u_host.frame(w);
        if (armed) begin // armed frame fills the sequence word
            exp_seq = w;
            armed = 1'b0;
        end else if (w[15]) begin // write bit is the msb
            exp_ctrl = w[15:4];
            armed = !w[14] && w[7];
        end
        pm = exp_ctrl[5:4];
        `CHK(ctrl_word_o, exp_ctrl);
        `CHK(seq_word_o, exp_seq);
        `CHK(pwr_state_o, {pm[1] ^ pm[0], !pm[0]});
        `CHK(track_o, pm == 2'h3 && prev_pwr != 2'h3);
        prev_pwr = {pm[1] ^ pm[0], !pm[0]};
    endtask : xfer
    initial begin
        seed = 49104;
        repeat (8) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        `CHK(pwr_state_o, 2'h3);
        `CHK(ctrl_word_o, 12'h0A5);
        xfer(16'hFFFF);
        xfer(16'hFFFF);
        `CHK(config_valid_o, 1'b0);
        xfer(16'h8300);
        `CHK(config_valid_o, 1'b1);
        $display("init test done");
        for (int i = 0; i < 4; i++) begin // every mode, then a dummy frame
            rv = $random(seed);
            xfer({2'b10, rv[3:0], 2'(3 - i), 8'h00});
            xfer({1'b0, rv[18:4]});
        end
        $display("mode test done");
        xfer(16'h8380);
        xfer(rv[31:16]);
        $display("sequence test done");
        // supply applied again mid-run; with one dummy skipped, the third rise is missing and the setup is not yet held
        reset_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        reset_i <= 1'b0;
        exp_ctrl = 12'h0A5;
        exp_seq = 16'h0000;
        prev_pwr = 2'h3;
        armed = 1'b0;
        @(posedge mclk_i);
        `CHK(pwr_state_o, 2'h3);
        `CHK(seq_word_o, 16'h0000);
        xfer(16'hFFFF);
        xfer(16'h8300);
        `CHK(config_valid_o, 1'b0);
        $display("reset test done");
        final_report();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        final_report();
    end
endmodule : test_adc_power_mode_sequencer
`default_nettype wire
